// *** hdl/aslim_pkg.sv ***
// Shared constants for the axis stop and limit input block.
// Assumes one 10 MHz reference clock and a synchronous active-high reset.
package aslim_pkg;
   localparam int NAX = 4;
   localparam int AW = 8;
   localparam int DW = 32;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_EXT = 8'h04;
   localparam logic [7:0] OFS_CMD = 8'h08;
   localparam logic [7:0] OFS_SUB = 8'h0C;
   localparam logic [7:0] OFS_IRQ_ST = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   // Control register fields
   localparam int CTRL_SD_LATCH = 0;
   localparam int CTRL_SD_POLNEG = 4;
   localparam int CTRL_EL_DECEL = 8;
   localparam int CTRL_W = 12;
   localparam logic [11:0] CTRL_RST = 12'h0F0;
   // Command register fields
   localparam int CMD_START = 0;
   localparam int CMD_ARM = 4;
   localparam int CMD_DRV_START = 8;
   localparam int CMD_DRV_STOP = 9;
   localparam int CMD_LATCH_CLR = 12;
   // Synchroniser vector layout
   localparam int SY_EMG = 0;
   localparam int SY_START = 1;
   localparam int SY_STOP = 2;
   localparam int SY_POL = 3;
   localparam int SY_PLUS = 7;
   localparam int SY_MINUS = 11;
   localparam int SY_SD = 15;
   localparam int SY_W = 19;
   localparam logic [18:0] SY_RST = 19'h0_0007;
   // Interrupt status layout
   localparam int IRQ_EMG = 0;
   localparam int IRQ_LIMIT = 1;
   localparam int IRQ_SLOW = 5;
   localparam int IRQ_W = 9;
   localparam logic [8:0] IRQ_RST = 9'h000;
endpackage

// *** hdl/aslim_axis_if.sv ***
// Per-axis link between the top block and one axis channel.
// Assumes all members are on the reference clock.
`timescale 1ns/10ps
`default_nettype none
interface aslim_axis_if;
   logic polSel;
   logic plusEl;
   logic minusEl;
   logic sdIn;
   logic sdLatchMode;
   logic sdPolNeg;
   logic elDecel;
   logic moving;
   logic dirMinus;
   logic latchClr;
   logic plusAct;
   logic minusAct;
   logic sdLvl;
   logic sdLatched;
   logic immStop;
   logic decStop;
   logic slowReq;
   modport top (output polSel, plusEl, minusEl, sdIn, sdLatchMode, sdPolNeg, elDecel,
      moving, dirMinus, latchClr, input plusAct, minusAct, sdLvl, sdLatched, immStop,
      decStop, slowReq);
   modport chan (input polSel, plusEl, minusEl, sdIn, sdLatchMode, sdPolNeg, elDecel,
      moving, dirMinus, latchClr, output plusAct, minusAct, sdLvl, sdLatched, immStop,
      decStop, slowReq);
endinterface
`default_nettype wire

// *** hdl/aslim_axis_chan.sv ***
// One axis channel: limit polarity, limit stops, slowdown level or latch.
// Assumes inputs are already synchronised to ref_clk by the top block.
`timescale 1ns/10ps
`default_nettype none
module aslim_axis_chan (
   input wire logic ref_clk,
   input wire logic sys_rst,
   aslim_axis_if.chan ax
);
   typedef struct packed {
      logic plusAct;
      logic minusAct;
      logic sdLvl;
      logic sdLatched;
      logic immStop;
      logic decStop;
      logic slowReq;
   } aslim_chan_st_t;

   aslim_chan_st_t q_ff;
   aslim_chan_st_t nxt_q;
   logic plusAct;
   logic minusAct;
   logic sdAct;
   logic stopHit;

   // Polarity decode and stop decisions
   always_comb begin
      nxt_q = q_ff;
      plusAct = ax.polSel ? ~ax.plusEl : ax.plusEl;
      minusAct = ax.polSel ? ~ax.minusEl : ax.minusEl;
      sdAct = ax.sdPolNeg ? ~ax.sdIn : ax.sdIn;
      stopHit = (plusAct & ax.moving & ~ax.dirMinus)
         | (minusAct & ax.moving & ax.dirMinus);
      nxt_q.plusAct = plusAct;
      nxt_q.minusAct = minusAct;
      nxt_q.sdLvl = sdAct;
      // Latched event: set wins over clear
      nxt_q.sdLatched = (q_ff.sdLatched & ~ax.latchClr) | (sdAct & ax.sdLatchMode);
      nxt_q.immStop = stopHit & ~ax.elDecel;
      nxt_q.decStop = stopHit & ax.elDecel;
      nxt_q.slowReq = (ax.sdLatchMode ? nxt_q.sdLatched : sdAct)
         & ax.moving & ~ax.dirMinus;
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign ax.plusAct = q_ff.plusAct;
   assign ax.minusAct = q_ff.minusAct;
   assign ax.sdLvl = q_ff.sdLvl;
   assign ax.sdLatched = q_ff.sdLatched;
   assign ax.immStop = q_ff.immStop;
   assign ax.decStop = q_ff.decStop;
   assign ax.slowReq = q_ff.slowReq;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   plus_limit_stop_a: assert property (
      (!ax.polSel && ax.plusEl && ax.moving && !ax.dirMinus) |=> (ax.immStop || ax.decStop))
      else $error("plus limit did not stop axis");
   minus_limit_stop_a: assert property (
      (ax.polSel && !ax.minusEl && ax.moving && ax.dirMinus) |=> (ax.immStop || ax.decStop))
      else $error("minus limit did not stop axis");
   limit_polarity_a: assert property (
      ##1 (ax.plusAct == ($past(ax.plusEl) ^ $past(ax.polSel))))
      else $error("limit polarity wrong");
   sd_latch_hold_a: assert property (
      (ax.sdLatched && !ax.latchClr) |=> ax.sdLatched)
      else $error("slowdown latch lost");
endmodule // aslim_axis_chan
`default_nettype wire

// *** hdl/aslim_top.sv ***
// Top of the axis stop and limit input block: pin synchronisers, shared
// start/stop lines, emergency halt, register port, interrupt, four axes.
// Assumes the motion engine reports axis motion and direction on ref_clk.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module aslim_top (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [31:0] regRdData,
   input wire logic emergencyHaltIn_n,
   input wire logic syncStartLineRd_n,
   output logic syncStartLineDrv_n,
   output logic syncStartLineOe,
   input wire logic syncStopLineRd_n,
   output logic syncStopLineDrv_n,
   output logic syncStopLineOe,
   input wire logic [3:0] limitPolaritySel,
   input wire logic [3:0] plusEndLimitIn,
   input wire logic [3:0] minusEndLimitIn,
   input wire logic [3:0] plusSlowdownIn,
   input wire logic [3:0] axisMoving,
   input wire logic [3:0] axisDirMinus,
   output logic [3:0] axisStartGo,
   output logic [3:0] axisHaltNow,
   output logic [3:0] axisDecelStop,
   output logic [3:0] axisSlowReq,
   output logic irq
);
   typedef struct packed {
      logic [18:0] s1;
      logic [18:0] s2;
      logic emgPrev;
      logic startPrev;
      logic [11:0] ctrl;
      logic [3:0] arm;
      logic [3:0] latchClr;
      logic [8:0] irqSt;
      logic [8:0] irqMask;
      logic [31:0] rdata;
      logic startOe;
      logic stopOe;
      logic lineDrv;
      logic [3:0] startGo;
      logic [3:0] haltNow;
      logic [3:0] decelStop;
      logic [3:0] slowReq;
      logic irq;
   } aslim_top_st_t;

   aslim_top_st_t q_ff;
   aslim_top_st_t nxt_q;
   aslim_axis_if ax[aslim_pkg::NAX] ();
   logic [3:0] chImm;
   logic [3:0] chDec;
   logic [3:0] chSlow;
   logic [15:0] subStat;
   logic emgAct;
   logic startLow;
   logic stopLow;
   logic startEdge;
   logic cmdWr;
   logic [3:0] startReq;
   logic [3:0] consumed;
   logic [3:0] armIdle;
   logic [8:0] ev;
   logic [8:0] irqClr;
   logic [2:0] lineLvl;

   // Four axis channels with their links
   genvar g;
   generate
      for (g = 0; g < aslim_pkg::NAX; g++) begin : gAxis
         assign ax[g].polSel = q_ff.s2[aslim_pkg::SY_POL + g];
         assign ax[g].plusEl = q_ff.s2[aslim_pkg::SY_PLUS + g];
         assign ax[g].minusEl = q_ff.s2[aslim_pkg::SY_MINUS + g];
         assign ax[g].sdIn = q_ff.s2[aslim_pkg::SY_SD + g];
         assign ax[g].sdLatchMode = q_ff.ctrl[aslim_pkg::CTRL_SD_LATCH + g];
         assign ax[g].sdPolNeg = q_ff.ctrl[aslim_pkg::CTRL_SD_POLNEG + g];
         assign ax[g].elDecel = q_ff.ctrl[aslim_pkg::CTRL_EL_DECEL + g];
         assign ax[g].moving = axisMoving[g];
         assign ax[g].dirMinus = axisDirMinus[g];
         assign ax[g].latchClr = q_ff.latchClr[g];
         assign chImm[g] = ax[g].immStop;
         assign chDec[g] = ax[g].decStop;
         assign chSlow[g] = ax[g].slowReq;
         assign subStat[4*g +: 4] = {ax[g].sdLatched, ax[g].sdLvl, ax[g].minusAct,
            ax[g].plusAct};
         aslim_axis_chan uChan (
            .ref_clk(ref_clk),
            .sys_rst(sys_rst),
            .ax(ax[g])
         );
      end
   endgenerate

   // Decoded levels of the shared lines
   assign emgAct = ~q_ff.s2[aslim_pkg::SY_EMG];
   assign startLow = ~q_ff.s2[aslim_pkg::SY_START];
   assign stopLow = ~q_ff.s2[aslim_pkg::SY_STOP];
   assign startEdge = startLow & ~q_ff.startPrev;
   assign cmdWr = regWrStb && (regAddr == aslim_pkg::OFS_CMD);
   assign armIdle = q_ff.arm & ~axisMoving;
   assign lineLvl = q_ff.s2[2:0];

   // Next state of the whole block
   always_comb begin
      nxt_q = q_ff;
      // Two-stage synchronisers on every pin
      nxt_q.s1 = {plusSlowdownIn, minusEndLimitIn, plusEndLimitIn, limitPolaritySel,
         syncStopLineRd_n, syncStartLineRd_n, emergencyHaltIn_n};
      nxt_q.s2 = q_ff.s1;
      nxt_q.emgPrev = emgAct;
      nxt_q.startPrev = startLow;
      // Command pulses
      startReq = cmdWr ? regWrData[aslim_pkg::CMD_START +: 4] : 4'h0;
      nxt_q.startOe = cmdWr & regWrData[aslim_pkg::CMD_DRV_START];
      nxt_q.stopOe = cmdWr & regWrData[aslim_pkg::CMD_DRV_STOP];
      nxt_q.latchClr = cmdWr ? regWrData[aslim_pkg::CMD_LATCH_CLR +: 4] : 4'h0;
      // Starts: direct or on the shared line, refused during emergency
      consumed = q_ff.arm & {4{startEdge}};
      nxt_q.startGo = (startReq | (armIdle & {4{startEdge}})) & ~axisMoving
         & {4{~emgAct}};
      nxt_q.arm = (q_ff.arm & ~consumed)
         | (cmdWr ? regWrData[aslim_pkg::CMD_ARM +: 4] : 4'h0);
      // Immediate halts: emergency, shared stop line, limit
      nxt_q.haltNow = {4{emgAct | stopLow}} | chImm;
      nxt_q.decelStop = chDec;
      nxt_q.slowReq = chSlow;
      // Sticky interrupt events, set wins over clear
      ev = {chSlow, chImm | chDec, emgAct & ~q_ff.emgPrev & (|axisMoving)};
      irqClr = (regWrStb && (regAddr == aslim_pkg::OFS_IRQ_ST)) ? regWrData[8:0] : 9'h000;
      nxt_q.irqSt = (q_ff.irqSt & ~irqClr) | ev;
      nxt_q.irq = |(q_ff.irqSt & q_ff.irqMask);
      // Register writes
      if (regWrStb && (regAddr == aslim_pkg::OFS_CTRL)) begin
         nxt_q.ctrl = regWrData[11:0];
      end
      if (regWrStb && (regAddr == aslim_pkg::OFS_IRQ_MASK)) begin
         nxt_q.irqMask = regWrData[8:0];
      end
      // Read data stands only in the cycle after the strobe
      nxt_q.rdata = 32'h0000_0000;
      if (regRdStb) begin
         case (regAddr)
            aslim_pkg::OFS_CTRL: nxt_q.rdata = {20'h0_0000, q_ff.ctrl};
            aslim_pkg::OFS_EXT: nxt_q.rdata = {25'h000_0000, axisMoving,
               lineLvl};
            aslim_pkg::OFS_SUB: nxt_q.rdata = {16'h0000, subStat};
            aslim_pkg::OFS_IRQ_ST: nxt_q.rdata = {23'h00_0000, q_ff.irqSt};
            aslim_pkg::OFS_IRQ_MASK: nxt_q.rdata = {23'h00_0000, q_ff.irqMask};
            default: nxt_q.rdata = 32'h0000_0000;
         endcase
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         q_ff <= '0;
         q_ff.s1 <= aslim_pkg::SY_RST;
         q_ff.s2 <= aslim_pkg::SY_RST;
         q_ff.ctrl <= aslim_pkg::CTRL_RST;
         q_ff.irqSt <= aslim_pkg::IRQ_RST;
         q_ff.irqMask <= aslim_pkg::IRQ_RST;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // Outputs straight from flip-flops
   assign regRdData = q_ff.rdata;
   assign syncStartLineDrv_n = q_ff.lineDrv;
   assign syncStartLineOe = q_ff.startOe;
   assign syncStopLineDrv_n = q_ff.lineDrv;
   assign syncStopLineOe = q_ff.stopOe;
   assign axisStartGo = q_ff.startGo;
   assign axisHaltNow = q_ff.haltNow;
   assign axisDecelStop = q_ff.decelStop;
   assign axisSlowReq = q_ff.slowReq;
   assign irq = q_ff.irq;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   emg_no_start_a: assert property (emgAct |=> (axisStartGo == 4'h0))
      else $error("start taken during emergency");
   emg_halt_all_a: assert property ($fell(q_ff.s2[0]) |=> (&axisHaltNow))
      else $error("emergency did not halt all axes");
   emg_sync_depth_a: assert property (
      (!emergencyHaltIn_n [*3]) |=> (&axisHaltNow))
      else $error("emergency latency beyond two stages");
   stop_line_halt_a: assert property (stopLow |=> (&axisHaltNow))
      else $error("stop line did not halt axes");
   start_line_go_a: assert property (
      (startEdge && !emgAct && !cmdWr) |=> (axisStartGo == $past(armIdle)))
      else $error("start line did not start armed axes");
   ext_status_read_a: assert property (
      (regRdStb && regAddr == aslim_pkg::OFS_EXT) |=> (regRdData[2:0] == $past(lineLvl)))
      else $error("extension status wrong");
   sub_status_read_a: assert property (
      (regRdStb && regAddr == aslim_pkg::OFS_SUB) |=> (regRdData[15:0] == $past(subStat)))
      else $error("sub status wrong");
   irq_level_a: assert property (((q_ff.irqSt & q_ff.irqMask) != 9'h000) |=> irq)
      else $error("interrupt not raised");
   emg_refuse_c: cover property (emgAct && cmdWr && (regWrData[3:0] != 4'h0));
   line_start_c: cover property (startEdge && (q_ff.arm != 4'h0));
   limit_stop_c: cover property ((chImm | chDec) != 4'h0);
   sd_latch_c: cover property (chSlow != 4'h0 && q_ff.ctrl[3:0] != 4'h0);
endmodule // aslim_top
`default_nettype wire

// *** verification/aslim_field_model.sv ***
// Field side model: limit and slowdown switches, emergency button, peers.
// Assumes the bench sets switch states right after ref_clk edges.
`timescale 1ns/10ps
`default_nettype none
module aslim_field_model (
   input wire logic startOe,
   input wire logic startDrv_n,
   input wire logic stopOe,
   input wire logic stopDrv_n,
   input wire logic peerStart,
   input wire logic peerStop,
   input wire logic emgOn,
   input wire logic [3:0] polSel,
   input wire logic [3:0] sdPolNeg,
   input wire logic [3:0] plusAct,
   input wire logic [3:0] minusAct,
   input wire logic [3:0] sdAct,
   output logic startLine_n,
   output logic stopLine_n,
   output logic emgPin_n,
   output logic [3:0] plusPin,
   output logic [3:0] minusPin,
   output logic [3:0] sdPin
);
   // Pulled-up wired lines, low while any controller pulls them
   assign startLine_n = ~((startOe & ~startDrv_n) | peerStart);
   assign stopLine_n = ~((stopOe & ~stopDrv_n) | peerStop);
   assign emgPin_n = ~emgOn;
   // Switch pins encoded by the selected polarity
   assign plusPin = plusAct ^ polSel;
   assign minusPin = minusAct ^ polSel;
   assign sdPin = sdAct ^ sdPolNeg;
endmodule // aslim_field_model
`default_nettype wire

// *** verification/aslim_top_tb.sv ***
// Self-checking bench for the axis stop and limit input block.
// Assumes the field model drives every pin but limitPolaritySel, which the bench drives; the bench plays motion engine.
`timescale 1ns/10ps
`default_nettype none
module aslim_top_tb;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic emgOn = 1'h0;
   logic peerStart = 1'h0;
   logic peerStop = 1'h0;
   logic [3:0] polSel = 4'h0;
   logic [3:0] sdPolNeg = 4'hF;
   logic [3:0] plusAct = 4'h0;
   logic [3:0] minusAct = 4'h0;
   logic [3:0] sdAct = 4'h0;
   logic [3:0] moving = 4'h0;
   logic [3:0] dirMinus = 4'h0;
   logic [3:0] goSeen = 4'h0;
   logic [1:0] oeSeen = 2'h0;
   logic [31:0] rdat, d;
   logic stRd_n, stDrv_n, stOe, spRd_n, spDrv_n, spOe, emg_n, irq;
   logic [3:0] plusPin, minusPin, sdPin, go, halt, decel, slow;
   int nErrors = 0;
   int totalChecks = 0;
   int cyc = 0;

   aslim_top dut (.ref_clk(clk), .sys_rst(rst), .regAddr(addr), .regWrData(wdat),
      .regWrStb(wr), .regRdStb(rd), .regRdData(rdat), .emergencyHaltIn_n(emg_n),
      .syncStartLineRd_n(stRd_n), .syncStartLineDrv_n(stDrv_n), .syncStartLineOe(stOe),
      .syncStopLineRd_n(spRd_n), .syncStopLineDrv_n(spDrv_n), .syncStopLineOe(spOe),
      .limitPolaritySel(polSel), .plusEndLimitIn(plusPin), .minusEndLimitIn(minusPin),
      .plusSlowdownIn(sdPin), .axisMoving(moving), .axisDirMinus(dirMinus),
      .axisStartGo(go), .axisHaltNow(halt), .axisDecelStop(decel),
      .axisSlowReq(slow), .irq(irq));
   aslim_field_model field (.startOe(stOe), .startDrv_n(stDrv_n), .stopOe(spOe),
      .stopDrv_n(spDrv_n), .peerStart(peerStart), .peerStop(peerStop), .emgOn(emgOn),
      .polSel(polSel), .sdPolNeg(sdPolNeg), .plusAct(plusAct), .minusAct(minusAct),
      .sdAct(sdAct), .startLine_n(stRd_n), .stopLine_n(spRd_n), .emgPin_n(emg_n),
      .plusPin(plusPin), .minusPin(minusPin), .sdPin(sdPin));

   // Clock, hang guard and sticky capture of one-cycle pulses
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      // Captures start from known zero, the block outputs are unknown before reset
      if (rst) begin
         goSeen <= 4'h0;
         oeSeen <= 2'h0;
      end else begin
         goSeen <= goSeen | go;
         oeSeen <= oeSeen | {spOe, stOe};
      end
      if (cyc == 5000) begin
         nErrors++;
         finalReport;
      end
   end

   task automatic check(input logic [31:0] s, input logic [31:0] e, input string m);
      totalChecks++;
      if (s !== e) begin
         nErrors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic wrReg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdat <= v;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic rdReg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 v = rdat;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic finalReport;
      if (nErrors == 0 && totalChecks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Reset values, unmapped read, start, emergency halt and interrupt
   task automatic tEmg;
      rdReg(aslim_pkg::OFS_CTRL, d);
      check(d, 32'h0000_00F0, "ctrl reset");
      rdReg(8'h40, d);
      check(d, 32'h0000_0000, "unmapped read");
      wrReg(aslim_pkg::OFS_CMD, 32'h0000_0005);
      idle(2);
      check(goSeen, 4'h5, "direct start");
      @(posedge clk);
      moving <= 4'h5;
      emgOn <= 1'h1;
      idle(1);
      check(halt, 4'h0, "halt before sync");
      idle(4);
      check(halt, 4'hF, "emergency halt");
      check(irq, 1'h0, "masked irq");
      // Extension status: [0] emergency, [1] start, [2] stop, [6:3] moving
      rdReg(aslim_pkg::OFS_EXT, d);
      check(d[6:0], 7'h2E, "ext status");
      goSeen = 4'h0;
      wrReg(aslim_pkg::OFS_CMD, 32'h0000_000A);
      idle(3);
      check(goSeen, 4'h0, "start refused");
      wrReg(aslim_pkg::OFS_IRQ_MASK, 32'h0000_0001);
      idle(2);
      check(irq, 1'h1, "emergency irq");
      @(posedge clk);
      emgOn <= 1'h0;
      moving <= 4'h0;
      idle(5);
      wrReg(aslim_pkg::OFS_IRQ_ST, 32'h0000_0001);
      idle(2);
      check(irq, 1'h0, "irq cleared");
   endtask

   // Shared start and stop lines, from peers and driven by us
   task automatic tLines;
      goSeen = 4'h0;
      wrReg(aslim_pkg::OFS_CMD, 32'h0000_0030);
      @(posedge clk);
      peerStart <= 1'h1;
      idle(5);
      check(goSeen, 4'h3, "line start");
      rdReg(aslim_pkg::OFS_EXT, d);
      check(d[2:0], 3'h5, "start level");
      @(posedge clk);
      peerStart <= 1'h0;
      peerStop <= 1'h1;
      idle(5);
      check(halt, 4'hF, "line stop");
      rdReg(aslim_pkg::OFS_EXT, d);
      check(d[2:0], 3'h3, "stop level");
      @(posedge clk);
      peerStop <= 1'h0;
      idle(5);
      goSeen = 4'h0;
      oeSeen = 2'h0;
      wrReg(aslim_pkg::OFS_CMD, 32'h0000_0100);
      wrReg(aslim_pkg::OFS_CMD, 32'h0000_0200);
      idle(5);
      check(oeSeen, 2'h3, "lines driven");
      check({stDrv_n, spDrv_n}, 2'h0, "lines pulled low");
      check(goSeen, 4'h0, "arm consumed");
   endtask

   // End limits under both polarities, immediate and decelerating
   task automatic tLimit;
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         polSel <= {3'h0, p[0]};
         moving <= 4'h1;
         minusAct <= 4'h1;
         idle(5);
         check(halt[0], 1'h0, "minus limit feeding plus");
         @(posedge clk);
         plusAct <= 4'h1;
         idle(5);
         check(halt[0], 1'h1, "plus limit stop");
         rdReg(aslim_pkg::OFS_SUB, d);
         check(d[1:0], 2'h3, "limit levels");
         @(posedge clk);
         plusAct <= 4'h0;
         minusAct <= 4'h0;
         idle(5);
         check(halt[0], 1'h0, "limit released");
      end
      wrReg(aslim_pkg::OFS_CTRL, 32'h0000_01F0);
      // Earlier limit stops left events behind, clear them first
      wrReg(aslim_pkg::OFS_IRQ_ST, 32'h0000_01FF);
      @(posedge clk);
      dirMinus <= 4'h1;
      minusAct <= 4'h1;
      idle(5);
      check({halt[0], decel[0]}, 2'h1, "minus decel stop");
      rdReg(aslim_pkg::OFS_IRQ_ST, d);
      check(d[1], 1'h1, "limit event");
      @(posedge clk);
      minusAct <= 4'h0;
      dirMinus <= 4'h0;
   endtask

   // Slowdown as level then latched, with both polarities
   task automatic tSlow;
      @(posedge clk);
      moving <= 4'h2;
      sdAct <= 4'h2;
      idle(5);
      check(slow, 4'h2, "level slowdown");
      rdReg(aslim_pkg::OFS_SUB, d);
      check(d[7:6], 2'h1, "slowdown level");
      @(posedge clk);
      sdAct <= 4'h0;
      idle(5);
      check(slow, 4'h0, "level released");
      wrReg(aslim_pkg::OFS_CTRL, 32'h0000_00D2);
      sdPolNeg <= 4'hD;
      idle(5);
      wrReg(aslim_pkg::OFS_CMD, 32'h0000_2000);
      idle(3);
      check(slow, 4'h0, "latch cleared");
      @(posedge clk);
      sdAct <= 4'h2;
      repeat (2) @(posedge clk);
      sdAct <= 4'h0;
      idle(5);
      check(slow, 4'h2, "latched slowdown");
      rdReg(aslim_pkg::OFS_SUB, d);
      check(d[7:6], 2'h2, "latch state");
      wrReg(aslim_pkg::OFS_CMD, 32'h0000_2000);
      idle(3);
      check(slow, 4'h0, "latch clear");
   endtask

   // Reset for 12 cycles, then every scenario in turn
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      tEmg;
      tLines;
      tLimit;
      tSlow;
      finalReport;
   end
endmodule // aslim_top_tb
`default_nettype wire
